/* include/uvf_pkg.sv */
package uvf_pkg;
	// command codes of the supervised registers
	localparam logic [7:0]  CMD_WARN_LIMIT   = 8'h43;
	localparam logic [7:0]  CMD_FAULT_LIMIT  = 8'h44;
	localparam logic [7:0]  CMD_REACTION     = 8'h45;
	// reset values
	localparam logic [15:0] WARN_LIMIT_RST   = 16'h0000;
	localparam logic [15:0] FAULT_LIMIT_RST  = 16'h0000;
	localparam logic [7:0]  REACTION_RST     = 8'h00;
	// reaction byte field positions
	localparam int          RESP_HI          = 7;
	localparam int          RESP_LO          = 6;
	localparam int          RETRY_HI         = 5;
	localparam int          RETRY_LO         = 3;
	localparam int          DELAY_HI         = 2;
	localparam int          DELAY_LO         = 0;
	// response and retry encodings
	localparam logic [1:0]  RESP_IGNORE      = 2'h0;
	localparam logic [1:0]  RESP_DELAY       = 2'h1;
	localparam logic [1:0]  RESP_DISABLE     = 2'h2;
	localparam logic [1:0]  RESP_HOLD        = 2'h3;
	localparam logic [2:0]  RETRY_NONE       = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER    = 3'h7;
	// timing: one delay unit, rounded up to whole clock cycles
	localparam int          CLK_PERIOD_NS    = 50;
	localparam int          DELAY_UNIT_NS    = 1000;
	localparam int          UNIT_CYCLES      = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          TIMER_W          = 16;
	localparam int          LIMIT_W          = 16;
	localparam int          REACTION_W       = 8;
	// supervisor states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_RUN,
		ST_DELAY,
		ST_RETRY,
		ST_LATCHED,
		ST_HOLD
	} uvf_state_e;
endpackage

/* include/uvf_cmd_if.sv */
`timescale 1ns/1ps
interface uvf_cmd_if;
	// request, core clock domain, strobe one cycle
	logic        reqStrobe;
	logic        reqWrite;
	logic [7:0]  reqCode;
	logic [15:0] reqData;
	// answer, combinational from the core in the strobe cycle
	logic [15:0] rspData;
	logic        rspUnknown;

	modport bridge (
		output reqStrobe,
		output reqWrite,
		output reqCode,
		output reqData,
		input  rspData,
		input  rspUnknown
	);
	modport core (
		input  reqStrobe,
		input  reqWrite,
		input  reqCode,
		input  reqData,
		output rspData,
		output rspUnknown
	);
endinterface

/* src/uvf_cmd_bridge.sv */
`timescale 1ns/1ps
module uvf_cmd_bridge (
	// clocks and reset
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        linkClk,
	// link side command port
	input  wire logic        cmdValid,
	input  wire logic        cmdWrite,
	input  wire logic [7:0]  cmdCode,
	input  wire logic [15:0] cmdData,
	output logic             cmdBusy,
	output logic             rspValid,
	output logic [15:0]      rspData,
	output logic             rspUnknown,
	// core side
	uvf_cmd_if.bridge        cmdIf
);
	// link domain state
	logic        busy, next_busy;
	logic        reqTgl, next_reqTgl;
	logic        holdWrite, next_holdWrite;
	logic [7:0]  holdCode, next_holdCode;
	logic [15:0] holdData, next_holdData;
	logic        ackSync1, ackSync2, ackSeen;
	logic        next_rspValid;
	logic [15:0] next_rspData;
	logic        next_rspUnknown;
	// core domain state
	logic        reqSync1, reqSync2, reqSeen;
	logic        ackTgl, next_ackTgl;
	logic [15:0] capData, next_capData;
	logic        capUnknown, next_capUnknown;

	// accept one command at a time; hold its fields stable until the answer returns
	always_comb
	begin
		next_busy       = busy;
		next_reqTgl     = reqTgl;
		next_holdWrite  = holdWrite;
		next_holdCode   = holdCode;
		next_holdData   = holdData;
		next_rspValid   = 1'b0;
		next_rspData    = rspData;
		next_rspUnknown = rspUnknown;
		if (cmdValid && !busy)
		begin
			next_busy      = 1'b1;
			next_reqTgl    = ~reqTgl;
			next_holdWrite = cmdWrite;
			next_holdCode  = cmdCode;
			next_holdData  = cmdData;
		end
		if (ackSync2 != ackSeen)
		begin
			// core captures are stable by the time the toggle is seen here
			next_busy       = 1'b0;
			next_rspValid   = 1'b1;
			next_rspData    = capData;
			next_rspUnknown = capUnknown;
		end
	end

	// link domain registers
	always_ff @(posedge linkClk or posedge reset)
	begin
		if (reset)
		begin
			busy       <= 1'b0;
			reqTgl     <= 1'b0;
			holdWrite  <= 1'b0;
			holdCode   <= 8'h00;
			holdData   <= 16'h0000;
			ackSync1   <= 1'b0;
			ackSync2   <= 1'b0;
			ackSeen    <= 1'b0;
			rspValid   <= 1'b0;
			rspData    <= 16'h0000;
			rspUnknown <= 1'b0;
		end
		else
		begin
			busy       <= next_busy;
			reqTgl     <= next_reqTgl;
			holdWrite  <= next_holdWrite;
			holdCode   <= next_holdCode;
			holdData   <= next_holdData;
			ackSync1   <= ackTgl;
			ackSync2   <= ackSync1;
			ackSeen    <= ackSync2;
			rspValid   <= next_rspValid;
			rspData    <= next_rspData;
			rspUnknown <= next_rspUnknown;
		end
	end

	assign cmdBusy = busy;

	// core side strobe from the synchronised toggle
	assign cmdIf.reqStrobe = reqSync2 ^ reqSeen;
	assign cmdIf.reqWrite  = holdWrite;
	assign cmdIf.reqCode   = holdCode;
	assign cmdIf.reqData   = holdData;

	// capture the answer and toggle the acknowledge back on the same clock edge
	always_comb
	begin
		next_ackTgl     = ackTgl;
		next_capData    = capData;
		next_capUnknown = capUnknown;
		if (cmdIf.reqStrobe)
		begin
			next_ackTgl     = ~ackTgl;
			next_capData    = cmdIf.rspData;
			next_capUnknown = cmdIf.rspUnknown;
		end
	end

	// core domain registers
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			reqSync1   <= 1'b0;
			reqSync2   <= 1'b0;
			reqSeen    <= 1'b0;
			ackTgl     <= 1'b0;
			capData    <= 16'h0000;
			capUnknown <= 1'b0;
		end
		else
		begin
			reqSync1   <= reqTgl;
			reqSync2   <= reqSync1;
			reqSeen    <= reqSync2;
			ackTgl     <= next_ackTgl;
			capData    <= next_capData;
			capUnknown <= next_capUnknown;
		end
	end
endmodule // uvf_cmd_bridge

/* src/uvf_fault_handler.sv */
`timescale 1ns/1ps
// Overview of operation
// - word command 0x43 holds the 16-bit under-voltage warning threshold, read/write
// - word command 0x44 holds the 16-bit under-voltage fault threshold, read/write
// - byte command 0x45: bits 7:6 response, 5:3 retries, 2:0 delay count
// - response 00b: keep running, never disable the output for this fault
// - response 01b: run for the delay, then apply retries if fault persists
// - response 10b: disable output at once, then follow the retry setting
// - response 11b: output off while the fault exists, back on once gone
// - status clear, clear-faults, reset or off-then-on command clear a latched fault
// - retry setting zero: no restart, output stays off until cleared
// - retry setting seven: restart attempts continue without limit
// - retry settings one to six: that many attempts, then off until cleared
// - restart attempt starts are spaced by the decoded delay time
// - delay count 0 to 7 means 1 to 128 units, doubling each step
// - continuous retry stops on an off command or another fault's shutdown
module uvf_fault_handler (
	// clocks and reset
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire logic                      linkClk,
	// command port, link clock domain
	input  wire logic                      cmdValid,
	input  wire logic                      cmdWrite,
	input  wire logic [7:0]                cmdCode,
	input  wire logic [uvf_pkg::LIMIT_W-1:0] cmdData,
	output logic                           cmdBusy,
	output logic                           rspValid,
	output logic [uvf_pkg::LIMIT_W-1:0]    rspData,
	output logic                           rspUnknown,
	// measurement and control, core clock domain
	input  wire logic [uvf_pkg::LIMIT_W-1:0] vout,
	input  wire logic                      operationOn,
	input  wire logic                      clearFaults,
	input  wire logic                      clearUvFault,
	input  wire logic                      otherFault,
	// control pin, asynchronous
	input  wire logic                      ctrlPin,
	// supervisor outputs
	output logic                           outputEnable,
	output logic                           uvWarning,
	output logic                           uvFault
);
	import uvf_pkg::*;

	uvf_cmd_if cmdIf ();

	// cross-domain command transport
	uvf_cmd_bridge bridge (
		.clk        (clk),
		.reset      (reset),
		.linkClk    (linkClk),
		.cmdValid   (cmdValid),
		.cmdWrite   (cmdWrite),
		.cmdCode    (cmdCode),
		.cmdData    (cmdData),
		.cmdBusy    (cmdBusy),
		.rspValid   (rspValid),
		.rspData    (rspData),
		.rspUnknown (rspUnknown),
		.cmdIf      (cmdIf.bridge)
	);

	logic [LIMIT_W-1:0]    warnLimit, next_warnLimit;
	logic [LIMIT_W-1:0]    faultLimit, next_faultLimit;
	logic [REACTION_W-1:0] reaction, next_reaction;
	logic                  ctrlSync1, ctrlSync2;
	logic                  commandOn, commandOnPrev, commandRise;
	logic [1:0]            respMode;
	logic [2:0]            retrySet;
	logic [2:0]            delayCode;
	logic [TIMER_W-1:0]    delayLoad;
	logic                  faultNow, warnNow, clearAny, shutdownOther;
	uvf_state_e            state, next_state;
	logic [TIMER_W-1:0]    timer, next_timer;
	logic [2:0]            attempts, next_attempts;
	logic                  attemptOn, next_attemptOn;
	logic                  next_outputEnable, next_uvWarning, next_uvFault;

	// register writes from the command port
	always_comb
	begin
		next_warnLimit  = warnLimit;
		next_faultLimit = faultLimit;
		next_reaction   = reaction;
		if (cmdIf.reqStrobe && cmdIf.reqWrite)
		begin
			case (cmdIf.reqCode)
				CMD_WARN_LIMIT:  next_warnLimit  = cmdIf.reqData;
				CMD_FAULT_LIMIT: next_faultLimit = cmdIf.reqData;
				CMD_REACTION:    next_reaction   = cmdIf.reqData[REACTION_W-1:0];
				default:         next_reaction   = reaction;
			endcase
		end
	end

	// read answers; unmapped codes answer zero and flag unknown
	always_comb
	begin
		cmdIf.rspData    = 16'h0000;
		cmdIf.rspUnknown = 1'b0;
		case (cmdIf.reqCode)
			CMD_WARN_LIMIT:  cmdIf.rspData = warnLimit;
			CMD_FAULT_LIMIT: cmdIf.rspData = faultLimit;
			CMD_REACTION:    cmdIf.rspData = {8'h00, reaction};
			default:         cmdIf.rspUnknown = 1'b1;
		endcase
	end

	// register file storage
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			warnLimit  <= WARN_LIMIT_RST;
			faultLimit <= FAULT_LIMIT_RST;
			reaction   <= REACTION_RST;
		end
		else
		begin
			warnLimit  <= next_warnLimit;
			faultLimit <= next_faultLimit;
			reaction   <= next_reaction;
		end
	end

	// field split and delay decode: count n means 2**n units
	assign respMode  = reaction[RESP_HI:RESP_LO];
	assign retrySet  = reaction[RETRY_HI:RETRY_LO];
	assign delayCode = reaction[DELAY_HI:DELAY_LO];
	assign delayLoad = (TIMER_W'(UNIT_CYCLES) << delayCode) - TIMER_W'(1);

	// comparisons against the limits, vout is same-clock logic
	assign faultNow = vout < faultLimit;
	assign warnNow  = vout < warnLimit;

	// control pin crosses in through two flops before use
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ctrlSync1     <= 1'b0;
			ctrlSync2     <= 1'b0;
			commandOnPrev <= 1'b0;
		end
		else
		begin
			ctrlSync1     <= ctrlPin;
			ctrlSync2     <= ctrlSync1;
			commandOnPrev <= commandOn;
		end
	end

	assign commandOn     = ctrlSync2 & operationOn;
	assign commandRise   = commandOn & ~commandOnPrev;
	assign clearAny      = clearFaults | clearUvFault | commandRise;
	assign shutdownOther = otherFault;

	// supervisor sequencing
	always_comb
	begin
		next_state     = state;
		next_timer     = (timer != '0) ? timer - TIMER_W'(1) : timer;
		next_attempts  = attempts;
		next_attemptOn = attemptOn;
		case (state)
			ST_OFF:
			begin
				if (commandOn)
					next_state = ST_RUN;
			end
			ST_RUN:
			begin
				if (faultNow)
				begin
					case (respMode)
						RESP_IGNORE: next_state = ST_RUN;
						RESP_DELAY:
						begin
							next_state = ST_DELAY;
							next_timer = delayLoad;
						end
						RESP_DISABLE:
						begin
							// immediate shutdown, then the retry setting decides
							next_state     = (retrySet == RETRY_NONE) ? ST_LATCHED : ST_RETRY;
							next_timer     = delayLoad;
							next_attempts  = 3'h0;
							next_attemptOn = 1'b0;
						end
						default: next_state = ST_HOLD;
					endcase
				end
			end
			ST_DELAY:
			begin
				if (timer == '0)
				begin
					if (faultNow)
					begin
						next_state     = (retrySet == RETRY_NONE) ? ST_LATCHED : ST_RETRY;
						next_timer     = delayLoad;
						next_attempts  = 3'h0;
						next_attemptOn = 1'b0;
					end
					else
						next_state = ST_RUN;
				end
			end
			ST_RETRY:
			begin
				// a failing attempt drops the output but keeps the start spacing
				if (attemptOn && faultNow)
					next_attemptOn = 1'b0;
				if (timer == '0)
				begin
					if (attemptOn && !faultNow)
						next_state = ST_RUN;
					else if (retrySet == RETRY_FOREVER)
					begin
						next_attemptOn = 1'b1;
						next_timer     = delayLoad;
					end
					else if (attempts < retrySet)
					begin
						next_attempts  = attempts + 3'h1;
						next_attemptOn = 1'b1;
						next_timer     = delayLoad;
					end
					else
					begin
						next_state     = ST_LATCHED;
						next_attemptOn = 1'b0;
					end
				end
			end
			ST_LATCHED: next_state = ST_LATCHED;
			ST_HOLD:
			begin
				if (!faultNow)
					next_state = ST_RUN;
			end
			default: next_state = ST_OFF;
		endcase
		// another fault's shutdown ends any active operation or retrying
		if (shutdownOther && (state == ST_RUN || state == ST_DELAY || state == ST_RETRY))
		begin
			next_state     = ST_LATCHED;
			next_attemptOn = 1'b0;
		end
		if (clearAny && (state == ST_LATCHED || state == ST_RETRY))
		begin
			next_state     = ST_RUN;
			next_attemptOn = 1'b0;
		end
		// an off command outranks everything
		if (!commandOn)
		begin
			next_state     = ST_OFF;
			next_attemptOn = 1'b0;
		end
	end

	// output enable follows the next state so it lines up with it
	always_comb
	begin
		next_outputEnable = (next_state == ST_RUN) || (next_state == ST_DELAY) ||
			((next_state == ST_RETRY) && next_attemptOn);
		// sticky flags: a new event wins over a clear in the same cycle
		next_uvFault   = (faultNow && outputEnable) || (uvFault && !clearAny);
		next_uvWarning = (warnNow && outputEnable) || (uvWarning && !clearAny);
	end

	// supervisor registers
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state        <= ST_OFF;
			timer        <= '0;
			attempts     <= 3'h0;
			attemptOn    <= 1'b0;
			outputEnable <= 1'b0;
			uvFault      <= 1'b0;
			uvWarning    <= 1'b0;
		end
		else
		begin
			state        <= next_state;
			timer        <= next_timer;
			attempts     <= next_attempts;
			attemptOn    <= next_attemptOn;
			outputEnable <= next_outputEnable;
			uvFault      <= next_uvFault;
			uvWarning    <= next_uvWarning;
		end
	end
endmodule // uvf_fault_handler

/* tb/uvf_assertions.sv */
`timescale 1ns/1ps
module uvf_assertions (
	// clocks and reset
	input wire logic                        clk,
	input wire logic                        reset,
	input wire logic                        linkClk,
	// command port
	input wire logic                        cmdValid,
	input wire logic                        cmdWrite,
	input wire logic [7:0]                  cmdCode,
	input wire logic [uvf_pkg::LIMIT_W-1:0] cmdData,
	input wire logic                        cmdBusy,
	input wire logic                        rspValid,
	// supervisor
	input wire logic [uvf_pkg::LIMIT_W-1:0] vout,
	input wire logic                        operationOn,
	input wire logic                        ctrlPin,
	input wire logic                        otherFault,
	input wire logic                        outputEnable,
	input wire logic                        uvFault
);
	import uvf_pkg::*;
	logic [15:0] shFault;
	logic [1:0]  shResp;
	logic [2:0]  onCnt;
	// shadow taken early, at the take edge; safe as vout stays high during writes
	always_ff @(posedge linkClk or posedge reset)
		if (reset)
		begin
			shFault <= FAULT_LIMIT_RST;
			shResp <= REACTION_RST[RESP_HI:RESP_LO];
		end
		else if (cmdValid && !cmdBusy && cmdWrite)
		begin
			if (cmdCode == CMD_FAULT_LIMIT)
				shFault <= cmdData;
			if (cmdCode == CMD_REACTION)
				shResp <= cmdData[RESP_HI:RESP_LO];
		end
	// cycles commanded on, saturating; covers the pin synchroniser lag
	always_ff @(posedge clk or posedge reset)
		if (reset)
			onCnt <= 3'h0;
		else if (!(operationOn && ctrlPin) || otherFault)
			onCnt <= 3'h0;
		else if (onCnt != 3'h7)
			onCnt <= onCnt + 3'h1;
	chk_rsp_pulse: assert property (@(posedge linkClk) disable iff (reset)
		rspValid |=> !rspValid) else $error("answer pulse too long");
	chk_busy_clear: assert property (@(posedge linkClk) disable iff (reset)
		rspValid |-> !cmdBusy) else $error("busy beside answer");
	chk_answer_time: assert property (@(posedge linkClk) disable iff (reset)
		$rose(cmdBusy) |-> ##[1:20] rspValid) else $error("answer late");
	chk_ignore_run: assert property (@(posedge clk) disable iff (reset)
		shResp == RESP_IGNORE && outputEnable && onCnt == 3'h7 |=> outputEnable)
		else $error("output dropped while ignoring");
	chk_disable_now: assert property (@(posedge clk) disable iff (reset)
		shResp == RESP_DISABLE && outputEnable && vout < shFault |=> !outputEnable)
		else $error("output kept on fault");
	chk_hold_off: assert property (@(posedge clk) disable iff (reset)
		shResp == RESP_HOLD && vout < shFault |=> !outputEnable)
		else $error("output on during fault");
	chk_hold_back: assert property (@(posedge clk) disable iff (reset)
		shResp == RESP_HOLD && vout >= shFault && onCnt == 3'h7 |=> outputEnable)
		else $error("output not back after fault");
	chk_fault_flag: assert property (@(posedge clk) disable iff (reset)
		outputEnable && onCnt == 3'h7 && vout < shFault |=> uvFault)
		else $error("fault flag missing");
endmodule // uvf_assertions

bind uvf_fault_handler uvf_assertions chk_u (
	.clk(clk), .reset(reset), .linkClk(linkClk), .cmdValid(cmdValid),
	.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData), .cmdBusy(cmdBusy),
	.rspValid(rspValid), .vout(vout), .operationOn(operationOn), .ctrlPin(ctrlPin),
	.otherFault(otherFault), .outputEnable(outputEnable), .uvFault(uvFault)
);

/* tb/uvf_host_model.sv */
`timescale 1ns/1ps
module uvf_host_model (
	// link clock
	input wire logic        linkClk,
	// command port
	output logic            cmdValid,
	output logic            cmdWrite,
	output logic [7:0]      cmdCode,
	output logic [15:0]     cmdData,
	input wire logic        cmdBusy,
	input wire logic        rspValid,
	input wire logic [15:0] rspData,
	input wire logic        rspUnknown
);
	initial
	begin
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdCode = 8'h00;
		cmdData = 16'h0000;
	end
	// one command after gap idle cycles; answer goes unknown if none comes
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		input int gap, output logic [15:0] q, output logic u);
		int n;
		q = 16'hxxxx;
		u = 1'bx;
		repeat (gap + 1) @(negedge linkClk);
		cmdValid = 1'b1;
		cmdWrite = w;
		cmdCode = c;
		cmdData = d;
		@(negedge linkClk);
		cmdValid = 1'b0;
		// released lines show the inverse, never a stale match
		cmdCode = ~c;
		cmdData = ~d;
		for (n = 0; n < 24 && !rspValid; n++)
			@(negedge linkClk);
		if (rspValid)
		begin
			q = rspData;
			u = rspUnknown;
		end
	endtask
endmodule // uvf_host_model

/* tb/uvf_fault_handler_tb.sv */
`timescale 1ns/1ps
module uvf_fault_handler_tb;
	import uvf_pkg::*;
	logic        clk = 1'b0;
	logic        linkClk = 1'b0;
	logic        reset = 1'b1;
	logic [15:0] vout = 16'hffff;
	logic        operationOn = 1'b0;
	logic        clearFaults = 1'b0;
	logic        clearUvFault = 1'b0;
	logic        otherFault = 1'b0;
	logic        ctrlPin = 1'b0;
	logic        cmdValid, cmdWrite, cmdBusy, rspValid, rspUnknown, u;
	logic        outputEnable, uvWarning, uvFault;
	logic [7:0]  cmdCode, c;
	logic [15:0] cmdData, rspData, q;
	logic [31:0] seed = 32'hc6a7;
	logic [2:0]  retryTab [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
	int          failures = 0;
	int          checkCount = 0;
	int          cycles = 0;
	int          n, tries, gap;
	always #25 clk = ~clk;
	initial
	begin
		#2.5;
		forever #6 linkClk = ~linkClk;
	end
	uvf_host_model host_u (.linkClk(linkClk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
		.cmdCode(cmdCode), .cmdData(cmdData), .cmdBusy(cmdBusy), .rspValid(rspValid),
		.rspData(rspData), .rspUnknown(rspUnknown));
	uvf_fault_handler dut_u (.clk(clk), .reset(reset), .linkClk(linkClk),
		.cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData),
		.cmdBusy(cmdBusy), .rspValid(rspValid), .rspData(rspData), .rspUnknown(rspUnknown),
		.vout(vout), .operationOn(operationOn), .clearFaults(clearFaults),
		.clearUvFault(clearUvFault), .otherFault(otherFault), .ctrlPin(ctrlPin),
		.outputEnable(outputEnable), .uvWarning(uvWarning), .uvFault(uvFault));
	// hang guard, well above the longest retry sequence
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			failures++;
			results();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [15:0] readBack(input logic [7:0] k, input logic [15:0] d);
		return (k == CMD_REACTION) ? {8'h00, d[7:0]} : d;
	endfunction
	function automatic int delayCycles(input logic [2:0] d);
		return UNIT_CYCLES << d;
	endfunction
	task automatic cmpVal(input string what, input logic [15:0] e, input logic [15:0] g);
		checkCount++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cmpBit(input string what, input logic e, input logic g);
		cmpVal(what, {15'h0, e}, {15'h0, g});
	endtask
	task automatic results();
		$display("checks %0d failures %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic setv(input logic [15:0] v, input int k);
		@(negedge clk);
		vout = v;
		repeat (k) @(negedge clk);
	endtask
	task automatic clr(input logic one);
		@(negedge clk);
		clearUvFault = one;
		clearFaults = !one;
		@(negedge clk);
		clearUvFault = 1'b0;
		clearFaults = 1'b0;
	endtask
	// clear and reprogram with vout high, so no fault races the new mode
	task automatic setup(input logic [7:0] r);
		setv(16'hffff, 2);
		clr(1'b0);
		host_u.xfer(1'b1, CMD_REACTION, {8'h00, r}, 0, q, u);
		repeat (10) @(negedge clk);
	endtask
	// negedges while the output keeps level lvl, capped at lim
	task automatic span(input logic lvl, input int lim, output int k);
		k = 0;
		while (outputEnable === lvl && k < lim)
		begin
			k++;
			@(negedge clk);
		end
	endtask
	task automatic countTries(input int lim, output int t, output int g);
		int k, m;
		t = 0;
		span(1'b1, 3000, k);
		span(1'b0, lim, g);
		m = g;
		while (m < lim && t < 8)
		begin
			t++;
			span(1'b1, 3000, k);
			span(1'b0, lim, m);
		end
	endtask
	initial
	begin
		repeat (3) @(negedge clk);
		reset = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			host_u.xfer(1'b0, CMD_WARN_LIMIT + 8'(i), 16'h0000, i, q, u);
			cmpVal("reset value", 16'h0000, q);
			cmpBit("unmapped", 1'(i == 3), u);
		end
		for (int i = 0; i < 12; i++)
		begin
			seed = xs(seed);
			c = CMD_WARN_LIMIT + 8'(seed[17:16] % 2'd3);
			host_u.xfer(1'b1, c, seed[15:0], 0, q, u);
			host_u.xfer(1'b0, c, 16'h0000, int'(seed[20:18]), q, u);
			cmpVal("read back", readBack(c, seed[15:0]), q);
		end
		$display("test registers done");
		host_u.xfer(1'b1, CMD_FAULT_LIMIT, 16'h1000, 0, q, u);
		host_u.xfer(1'b1, CMD_WARN_LIMIT, 16'h2000, 0, q, u);
		setup(8'h00);
		ctrlPin = 1'b1;
		operationOn = 1'b1;
		setv(16'h1800, 8);
		cmpBit("warning", 1'b1, uvWarning);
		cmpBit("no fault", 1'b0, uvFault);
		setv(16'h0800, 100);
		cmpBit("ignore on", 1'b1, outputEnable);
		cmpBit("fault flag", 1'b1, uvFault);
		setv(16'hffff, 2);
		clr(1'b1);
		cmpBit("bit clear", 1'b0, uvFault);
		// raise the warning again so the clear-all check has something to clear
		setv(16'h1800, 3);
		cmpBit("warning again", 1'b1, uvWarning);
		setv(16'hffff, 2);
		clr(1'b0);
		cmpBit("clear all", 1'b0, uvWarning);
		$display("test ignore done");
		setup(8'hc0);
		setv(16'h0800, 3);
		cmpBit("hold off", 1'b0, outputEnable);
		setv(16'hffff, 3);
		cmpBit("hold back", 1'b1, outputEnable);
		setup(8'h41);
		// fault gone before the delay expires: back to normal running, output kept
		setv(16'h0800, 10);
		setv(16'hffff, 60);
		cmpBit("delay recover", 1'b1, outputEnable);
		setv(16'h0800, 0);
		span(1'b1, 200, n);
		cmpBit("delay on", 1'b1, 1'(n >= delayCycles(3'h1) && n <= delayCycles(3'h1) + 2));
		span(1'b0, 100, n);
		cmpVal("no retry", 16'd100, 16'(n));
		$display("test hold and delay done");
		for (int i = 0; i < 5; i++)
		begin
			setup({RESP_DISABLE, retryTab[i], 3'(i % 4)});
			setv(16'h0800, 0);
			countTries(delayCycles(3'(i % 4)) + 5, tries, gap);
			cmpVal("tries", (retryTab[i] == RETRY_FOREVER) ? 16'd8 : 16'(retryTab[i]),
				16'(tries));
			if (retryTab[i] != RETRY_NONE)
				cmpVal("spacing", 16'(delayCycles(3'(i % 4))), 16'(gap));
		end
		$display("test retries done");
		@(negedge clk);
		operationOn = 1'b0;
		span(1'b0, 200, n);
		cmpVal("off stops", 16'd200, 16'(n));
		vout = 16'hffff;
		operationOn = 1'b1;
		repeat (8) @(negedge clk);
		cmpBit("off-on run", 1'b1, outputEnable);
		cmpBit("off-on clear", 1'b0, uvFault);
		otherFault = 1'b1;
		@(negedge clk);
		otherFault = 1'b0;
		span(1'b0, 200, n);
		cmpVal("other fault", 16'd200, 16'(n));
		$display("test stop done");
		results();
	end
endmodule // uvf_fault_handler_tb
